// file: rtl/parallel_host_strobe_port.sv
// Parallel host strobe port: register file reached by async CPU strobes
// What this block does
// - Write latched at write strobe rising edge
// - Read starts at read strobe falling edge
// - Data driven only while read and enable low
// - Enable high: bus released, strobes ignored
// - Address inputs select the accessed register
// - Trigger event starts a new frame
// - Low reset returns power-on state
// - Interrupt pulls line low, open drain
`default_nettype none
module parallel_host_strobe_port
  import host_port_pkg::*;
(
  input  wire logic              ref_clk_i,        // 100 MHz core clock
  input  wire logic              rst_n_i,          // Async reset, active low
  input  wire logic              chip_en_n_i,      // Chip enable pin, active low
  input  wire logic              wr_n_i,           // Write strobe pin, active low
  input  wire logic              rd_n_i,           // Read strobe pin, active low
  input  wire logic [ADDR_W-1:0] host_addr_i,      // Address pins
  input  wire logic [DATA_W-1:0] host_data_i,      // Data bus, input side
  output logic      [DATA_W-1:0] host_data_o,      // Data bus, output side
  output logic                   host_data_oe_o,   // High while port drives bus
  input  wire logic              frame_trigger_in_i, // Frame trigger pin
  output logic                   irq_n_o,          // Interrupt line value, always 0
  output logic                   irq_oe_o,         // High while pulling line low
  output logic                   frame_start_o,    // One-cycle frame start pulse
  output logic                   ready_o           // High once out of reset
);

  // Two-stage synchronisers for every pin
  logic [SYNC_STAGES-1:0] ce_sync_reg;     // Enable sync chain
  logic [SYNC_STAGES-1:0] wr_sync_reg;     // Write strobe sync chain
  logic [SYNC_STAGES-1:0] rd_sync_reg;     // Read strobe sync chain
  logic [SYNC_STAGES-1:0] fire_sync_reg;   // Trigger sync chain
  logic [ADDR_W-1:0]      addr_meta_reg;   // Address first stage
  logic [ADDR_W-1:0]      addr_sync_reg;   // Address second stage
  logic [DATA_W-1:0]      data_meta_reg;   // Data first stage
  logic [DATA_W-1:0]      data_sync_reg;   // Data second stage

  // Synchronisers; stage one is read only by stage two
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ce_sync_reg   <= '1;
      wr_sync_reg   <= '1;
      rd_sync_reg   <= '1;
      fire_sync_reg <= '0;
      addr_meta_reg <= '0;
      addr_sync_reg <= '0;
      data_meta_reg <= '0;
      data_sync_reg <= '0;
    end else begin
      ce_sync_reg   <= {ce_sync_reg[0], chip_en_n_i};
      wr_sync_reg   <= {wr_sync_reg[0], wr_n_i};
      rd_sync_reg   <= {rd_sync_reg[0], rd_n_i};
      fire_sync_reg <= {fire_sync_reg[0], frame_trigger_in_i};
      addr_meta_reg <= host_addr_i;
      addr_sync_reg <= addr_meta_reg;
      data_meta_reg <= host_data_i;
      data_sync_reg <= data_meta_reg;
    end
  end

  // Synchronised levels
  logic ce_low;      // Enable asserted
  logic wr_low;      // Write strobe asserted
  logic rd_low;      // Read strobe asserted
  logic fire_level;  // Trigger level
  assign ce_low     = ~ce_sync_reg[1];
  assign wr_low     = ~wr_sync_reg[1];
  assign rd_low     = ~rd_sync_reg[1];
  assign fire_level = fire_sync_reg[1];

  // Access state and captured values
  port_state_t       state_reg, state_next;      // Strobe tracking state
  logic [ADDR_W-1:0] addr_reg, addr_next;        // Latched target address
  logic [DATA_W-1:0] wdata_reg, wdata_next;      // Last data seen during write
  logic              wr_commit;                  // Write completes this cycle
  logic              rd_begin;                   // Read starts this cycle

  // Next state: an access needs both strobe and enable low
  always_comb begin
    state_next = state_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    wr_commit  = 1'b0;
    rd_begin   = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        // Enable high ignores both strobes
        if (ce_low && wr_low) begin
          state_next = ST_WRITE;
          addr_next  = addr_sync_reg;
          wdata_next = data_sync_reg;
        end else if (ce_low && rd_low) begin
          state_next = ST_READ;
          addr_next  = addr_sync_reg;
          rd_begin   = 1'b1;
        end
      end
      ST_WRITE: begin
        // Enable may rise with the strobe, so either ends the write
        if (!wr_low || !ce_low) begin
          state_next = ST_IDLE;
          wr_commit  = 1'b1;
        end else begin
          wdata_next = data_sync_reg;  // Track data until the rising edge
          addr_next  = addr_sync_reg;
        end
      end
      ST_READ: begin
        if (!rd_low || !ce_low) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      addr_reg  <= '0;
      wdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
    end
  end

  // Register array; only writes change contents, reads never do
  logic [DATA_W-1:0] regs_reg [REG_COUNT];  // Host-visible storage
  logic [DATA_W-1:0] frame_cnt_reg, frame_cnt_next;  // Frames started
  logic              fire_prev_reg;          // Trigger edge history
  logic              frame_pulse;            // Rising trigger edge

  assign frame_pulse    = fire_level & ~fire_prev_reg;
  assign frame_cnt_next = frame_pulse ? frame_cnt_reg + 8'h01 : frame_cnt_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_reg[i] <= REG_RESET;
      end
      frame_cnt_reg <= FRAME_RESET;
      fire_prev_reg <= 1'b0;
    end else begin
      if (wr_commit && addr_reg != FRAME_ADDR) begin
        regs_reg[addr_reg] <= wdata_reg;
      end
      frame_cnt_reg <= frame_cnt_next;
      fire_prev_reg <= fire_level;
    end
  end

  // Read data comes from a flop; the frame counter has its own address
  logic [DATA_W-1:0] rdata_reg, rdata_next;  // Registered read data
  always_comb begin
    rdata_next = rdata_reg;
    if (rd_begin) begin
      rdata_next = (addr_next == FRAME_ADDR) ? frame_cnt_reg : regs_reg[addr_next];
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Drive only while both read and enable remain low
  assign host_data_o    = rdata_reg;
  assign host_data_oe_o = (state_reg == ST_READ) && rd_low && ce_low;

  // Open drain: value fixed low, enable asserted while anything pending
  logic irq_pend_reg;  // Any bit of the pending register set
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_pend_reg <= 1'b0;
    end else begin
      irq_pend_reg <= |regs_reg[IRQ_ADDR];
    end
  end
  assign irq_n_o  = 1'b0;
  assign irq_oe_o = irq_pend_reg;

  // Ready one register stage after release; host may then hold enable low
  logic ready_reg;  // relies on this flag
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= 1'b1;
    end
  end
  assign ready_o       = ready_reg;
  assign frame_start_o = frame_pulse;

  // Checks
  wr_commit_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_commit && addr_reg != FRAME_ADDR |=> regs_reg[$past(addr_reg)] == $past(wdata_reg))
    else $error("write not stored");
  wr_ends_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == ST_WRITE && !ce_low |-> wr_commit)
    else $error("write not ended by enable");
  rd_start_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == ST_IDLE && ce_low && rd_low && !wr_low |=> state_reg == ST_READ)
    else $error("read not started");
  drive_only_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    host_data_oe_o |-> rd_low && ce_low)
    else $error("bus driven outside read");
  ce_high_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !ce_low && state_reg == ST_IDLE |=> state_reg == ST_IDLE && !host_data_oe_o)
    else $error("strobe accepted with enable high");
  addr_latch_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_begin |=> addr_reg == $past(addr_sync_reg))
    else $error("address not latched");
  frame_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    frame_pulse |=> frame_cnt_reg == $past(frame_cnt_reg) + 8'h01 ##1 !frame_start_o)
    else $error("frame not counted");
  ready_a: assert property (@(posedge ref_clk_i) $rose(rst_n_i) |=> ready_o)
    else $error("ready late after reset");
  irq_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (|regs_reg[IRQ_ADDR]) |=> irq_oe_o && !irq_n_o)
    else $error("interrupt not pulled low");
  rd_noside_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_reg == ST_READ |=> regs_reg[$past(addr_reg)] == $past(regs_reg[addr_reg]))
    else $error("read changed register");
  cov_write_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) wr_commit);
  cov_read_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) host_data_oe_o);
  cov_frame_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) frame_start_o);
  cov_irq_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) irq_oe_o);

endmodule : parallel_host_strobe_port
`default_nettype wire

// file: rtl/host_port_pkg.sv
// Constants shared by the parallel host strobe port
`default_nettype none
package host_port_pkg;
  localparam int unsigned ADDR_W      = 8;         // Address input width
  localparam int unsigned DATA_W      = 8;         // Data bus width
  localparam int unsigned REG_COUNT   = 256;       // One register per address
  localparam logic [7:0]  REG_RESET   = 8'h00;     // Power-on register contents
  localparam logic [7:0]  IRQ_ADDR    = 8'hFF;     // Interrupt pending register
  localparam logic [7:0]  FRAME_ADDR  = 8'hFE;     // Frame counter, read only
  localparam logic [7:0]  FRAME_RESET = 8'h00;     // Frame counter reset value
  localparam int unsigned SYNC_STAGES = 2;         // Pin synchroniser depth
  // Strobe edge tracking states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ  = 2'b10
  } port_state_t;
endpackage : host_port_pkg
`default_nettype wire

// file: verif/host_cpu_model.sv
// Host CPU model driving the asynchronous strobe port pins
`default_nettype none
module host_cpu_model
  import host_port_pkg::*;
(
  input  wire logic              clk_i,        // Bench clock
  output logic                   chip_en_n_o,  // Chip enable, active low
  output logic                   wr_n_o,       // Write strobe, active low
  output logic                   rd_n_o,       // Read strobe, active low
  output logic      [ADDR_W-1:0] addr_o,       // Address pins
  output logic      [DATA_W-1:0] bus_o,        // Resolved data bus level
  input  wire logic [DATA_W-1:0] dev_data_i,   // Device data, output side
  input  wire logic              dev_oe_i      // Device drives the bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] drv_reg = '0;  // Value the host puts on the bus
  logic              drv_en  = 1'b0; // High while the host drives
  logic [DATA_W-1:0] last_reg = '0; // Last bus level
  initial begin
    chip_en_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    addr_o = '0;
  end
  // No pull on the bus, so a floating bus shows a changing pattern
  always_comb begin
    if (dev_oe_i) bus_o = dev_data_i;
    else if (drv_en) bus_o = drv_reg;
    else bus_o = ~last_reg;
  end
  always @(posedge clk_i) last_reg <= bus_o;
  // Write cycle; enable held across or switched with the strobe
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d, input logic ce_n, input logic hold);
    addr_o = a;
    drv_reg = ~d; // Wrong byte first, so an early capture shows up
    drv_en = 1'b1;
    chip_en_n_o = ce_n | ~hold;
    repeat (3) @(negedge clk_i);
    chip_en_n_o = ce_n;
    wr_n_o = 1'b0;
    @(negedge clk_i);
    // Real byte settles three cycles before the rising edge
    drv_reg = d;
    repeat (3) @(negedge clk_i);
    wr_n_o = 1'b1;
    chip_en_n_o = ce_n | ~hold;
    repeat (4) @(negedge clk_i);
    chip_en_n_o = 1'b1;
    drv_en = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask : write_byte
  // Read cycle; returns data, drive state and drive state after release
  task automatic read_byte(input logic [7:0] a, input logic ce_n, input logic hold,
                           output logic [7:0] d, output logic oe, output logic oe_off);
    addr_o = a;
    chip_en_n_o = ce_n | ~hold;
    repeat (3) @(negedge clk_i);
    chip_en_n_o = ce_n;
    rd_n_o = 1'b0;
    repeat (5) @(negedge clk_i);
    d = bus_o;
    oe = dev_oe_i;
    rd_n_o = 1'b1;
    chip_en_n_o = ce_n | ~hold;
    repeat (3) @(negedge clk_i);
    oe_off = dev_oe_i;
    chip_en_n_o = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask : read_byte
endmodule : host_cpu_model
`default_nettype wire

// file: verif/tb_parallel_host_strobe_port.sv
// Self-checking bench for the parallel host strobe port
`default_nettype none
module tb_parallel_host_strobe_port
  import host_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Pins between bench, model and port
  logic ref_clk, rst_n, ce_n, wr_n, rd_n, fire, oe, irq_n, irq_oe, fs, ready;
  logic [7:0] addr, bus, dout, a, b, d, rdv, f, n;
  logic oe_on, oe_off;
  logic [7:0] mirror [256];  // Expected register contents
  int n_errors = 0;
  int total_checks = 0;
  int seed, i;
  parallel_host_strobe_port DUT (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .chip_en_n_i(ce_n),
    .wr_n_i(wr_n), .rd_n_i(rd_n), .host_addr_i(addr), .host_data_i(bus), .host_data_o(dout),
    .host_data_oe_o(oe), .frame_trigger_in_i(fire), .irq_n_o(irq_n), .irq_oe_o(irq_oe),
    .frame_start_o(fs), .ready_o(ready));
  host_cpu_model host (.clk_i(ref_clk), .chip_en_n_o(ce_n), .wr_n_o(wr_n), .rd_n_o(rd_n),
    .addr_o(addr), .bus_o(bus), .dev_data_i(dout), .dev_oe_i(oe));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Frame counter advances by one per trigger
  function automatic logic [7:0] frame_next(input logic [7:0] c);
    return c + 8'h01;
  endfunction : frame_next
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val
  task automatic complete_run;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // Trigger high eight cycles; start pulses counted through the fall too
  task automatic pulse_fire;
    n = 8'h00;
    fire = 1'b1;
    for (int k = 0; k < 12; k++) begin
      @(negedge ref_clk);
      if (fs === 1'b1) n++;
      if (k == 7) fire = 1'b0;
    end
  endtask : pulse_fire
  // Hang guard, far above the expected run length
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_errors++;
    complete_run();
  end
  initial begin
    seed = 32'h6089A761;
    rst_n = 1'b0;
    fire = 1'b0;
    for (i = 0; i < 256; i++) mirror[i] = REG_RESET;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check_val({7'h00, ready}, 8'h01);
    check_val({7'h00, irq_oe}, 8'h00);
    // Random traffic, both enable styles, edge addresses first
    for (i = 0; i < 24; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'hFD : 8'($random(seed) % 8'hFE);
      b = 8'($random(seed) % 8'hFE);
      d = 8'($random(seed));
      host.write_byte(a, d, 1'b0, i[0]);
      mirror[a] = d;
      host.read_byte(b, 1'b0, i[1], rdv, oe_on, oe_off);
      check_val(rdv, mirror[b]);
      check_val({6'h00, oe_on, oe_off}, 8'h02);
    end
    // Strobes with enable high are ignored
    host.write_byte(a, ~d, 1'b1, 1'b1);
    host.read_byte(a, 1'b1, 1'b1, rdv, oe_on, oe_off);
    check_val({7'h00, oe_on}, 8'h00);
    host.read_byte(a, 1'b0, 1'b0, rdv, oe_on, oe_off);
    check_val(rdv, mirror[a]);
    // Trigger events, frame counter read only
    f = FRAME_RESET;
    for (i = 0; i < 3; i++) begin
      pulse_fire();
      check_val(n, 8'h01);
      f = frame_next(f);
      host.write_byte(FRAME_ADDR, 8'hAA, 1'b0, 1'b1);
      host.read_byte(FRAME_ADDR, 1'b0, 1'b1, rdv, oe_on, oe_off);
      check_val(rdv, f);
    end
    // Each pending bit pulls the interrupt line
    for (i = 0; i < 9; i++) begin
      d = (i == 8) ? 8'h00 : (8'h01 << i);
      host.write_byte(IRQ_ADDR, d, 1'b0, 1'b0);
      check_val({6'h00, irq_oe, irq_n}, (i == 8) ? 8'h00 : 8'h02);
    end
    // Mid-run reset clears everything
    host.write_byte(IRQ_ADDR, 8'h80, 1'b0, 1'b0);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    check_val({5'h00, ready, irq_oe, oe}, 8'h00);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    host.read_byte(a, 1'b0, 1'b0, rdv, oe_on, oe_off);
    check_val(rdv, REG_RESET);
    check_val({7'h00, irq_oe}, 8'h00);
    complete_run();
  end
endmodule : tb_parallel_host_strobe_port
`default_nettype wire
